// ### gpb_pkg.sv
// package: register map, field layout and reset values of the gpio port bank
// Contract
// (RL1) every port pin has its own direction bit, independent of its neighbours
// (RL2) direction 0 makes the pin an input, 1 drives it from its latch
// (RL3) reading an output pin returns the latch, not the pin level
// (RL4) input pins are undriven and floating; reading returns the sampled pin level
// (RL5) writing an input pin only updates its latch; pin stays undriven
// (RL6) keypad port has eight software pull-ups and feeds the key wake-up function
// (RL7) external irq port has software pull-ups and selectable active edge per line
// (RL8) key wake-up request when AND of keypad input pins falls from 1 to 0
// (RL9) reset clears all direction bits so every pin starts as floating input
package gpb_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned NUM_PORTS = 2;
    // byte addresses of the register words
    localparam logic [11:0] KP_DATA_OFF = 12'h000;
    localparam logic [11:0] KP_DIR_OFF = 12'h004;
    localparam logic [11:0] KP_PULL_OFF = 12'h008;
    localparam logic [11:0] KP_PIN_OFF = 12'h00c;
    localparam logic [11:0] XP_DATA_OFF = 12'h010;
    localparam logic [11:0] XP_DIR_OFF = 12'h014;
    localparam logic [11:0] XP_PULL_OFF = 12'h018;
    localparam logic [11:0] XP_PIN_OFF = 12'h01c;
    localparam logic [11:0] EDGE_OFF = 12'h020;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h024;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h028;
    // bit positions of the irq-port pins that carry the external lines
    localparam int unsigned IRQ_A_PIN = 0;
    localparam int unsigned IRQ_B_PIN = 2;
    // status / mask / edge field positions
    localparam int unsigned ST_KEY_BIT = 0;
    localparam int unsigned ST_A_BIT = 1;
    localparam int unsigned ST_B_BIT = 2;
    localparam int unsigned ST_W = 3;
    localparam int unsigned EDGE_A_BIT = 0;
    localparam int unsigned EDGE_B_BIT = 1;
    localparam int unsigned EDGE_W = 2;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ### gpb_sync.sv
// three-stage pin synchroniser with a second/third stage agreement filter
`timescale 1ns/1ps
module gpb_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // stage one is read only by stage two, to keep metastability contained
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else if (ce)
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes only once the last two stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    level_out[i] <= 1'b0;
                else if (ce && (s2_q[i] == s3_q[i]))
                    level_out[i] <= s3_q[i];
            end
        end
    endgenerate
endmodule

// ### gpb_port_bank.sv
// gpio port bank: keypad port and external irq port with apb register access
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module gpb_port_bank #(
    parameter int unsigned PORT_W = gpb_pkg::PORT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORT_W-1:0] keypad_port_in,
    output logic [PORT_W-1:0] keypad_port_out,
    output logic [PORT_W-1:0] keypad_port_oe,
    output logic [PORT_W-1:0] keypad_pullup_en,
    input wire logic [PORT_W-1:0] ext_irq_port_in,
    output logic [PORT_W-1:0] ext_irq_port_out,
    output logic [PORT_W-1:0] ext_irq_port_oe,
    output logic [PORT_W-1:0] irq_port_pullup_en,
    output logic irq
);
    // register map, one word each, data in the low bits:
    //   0x00 keypad data: writes the latch, reads latch or pin per direction
    //   0x04 keypad direction, 1 = output
    //   0x08 keypad pull-up control
    //   0x0c keypad synchronised pin levels
    //   0x10 irq port data, same layout as the keypad data word
    //   0x14 irq port direction
    //   0x18 irq port pull-up control
    //   0x1c irq port synchronised pin levels
    //   0x20 edge select: bit 0 line a, bit 1 line b; 1 rising, 0 falling
    //   0x24 status, write one to clear: bit 0 key, bit 1 line a, bit 2 line b
    //   0x28 interrupt mask, same layout as the status word
    // line a sits on irq port bit 0, line b on bit 2
    // unmapped words read zero and answer with pslverr; writes to them are dropped
    // only byte lane 0 carries port data; the upper lanes are ignored
    // pull-ups act only while their pin is an input
    // pin levels reach the registers some four cycles after the pin moves
    // status sets a cycle after a filtered event; irq follows a cycle later
    // clock enable low freezes every register, the bus answer included
    logic [PORT_W-1:0] kp_latch_q;
    logic [PORT_W-1:0] kp_dir_q;
    logic [PORT_W-1:0] keypad_pullup_ctrl_q;
    logic [PORT_W-1:0] xp_latch_q;
    logic [PORT_W-1:0] xp_dir_q;
    logic [PORT_W-1:0] irq_port_pullup_ctrl_q;
    logic [gpb_pkg::EDGE_W-1:0] irq_edge_select_q;
    logic [gpb_pkg::ST_W-1:0] stat_q;
    logic [gpb_pkg::ST_W-1:0] mask_q;
    logic [gpb_pkg::ST_W-1:0] ev_set;
    logic [PORT_W-1:0] kp_pin;
    logic [PORT_W-1:0] xp_pin;
    logic kp_and_q;
    logic ext_irq_line_a_q;
    logic ext_irq_line_b_q;
    logic kp_and_d;
    logic ext_irq_line_a;
    logic ext_irq_line_b;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rdata_d;
    logic [31:0] wmask;

    // pin levels pass three stages before the logic looks at them
    gpb_sync #(
        .WIDTH(PORT_W)
    ) u_kp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(keypad_port_in),
        .level_out(kp_pin)
    );

    gpb_sync #(
        .WIDTH(PORT_W)
    ) u_xp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(ext_irq_port_in),
        .level_out(xp_pin)
    );

    // apb: zero-wait slave, writes and reads take effect in the access cycle
    assign wr_en = ce && psel && penable && pwrite;

    // byte lanes that a write may touch; only the low byte carries port data
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{pstrb[b]}};
    end

    // decode: misaligned or unmapped addresses answer with pslverr
    always_comb
    begin
        addr_ok = 1'b1;
        unique case (paddr)
            gpb_pkg::KP_DATA_OFF, gpb_pkg::KP_DIR_OFF, gpb_pkg::KP_PULL_OFF,
            gpb_pkg::KP_PIN_OFF, gpb_pkg::XP_DATA_OFF, gpb_pkg::XP_DIR_OFF,
            gpb_pkg::XP_PULL_OFF, gpb_pkg::XP_PIN_OFF, gpb_pkg::EDGE_OFF,
            gpb_pkg::IRQ_STAT_OFF, gpb_pkg::IRQ_MASK_OFF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // port data reads mix latch and pin per bit, chosen by direction
    always_comb
    begin
        rdata_d = gpb_pkg::RDATA_ZERO;
        unique case (paddr)
            gpb_pkg::KP_DATA_OFF:
                rdata_d[PORT_W-1:0] = (kp_dir_q & kp_latch_q) | (~kp_dir_q & kp_pin); // RL3 RL4
            gpb_pkg::KP_DIR_OFF: rdata_d[PORT_W-1:0] = kp_dir_q;
            gpb_pkg::KP_PULL_OFF: rdata_d[PORT_W-1:0] = keypad_pullup_ctrl_q;
            gpb_pkg::KP_PIN_OFF: rdata_d[PORT_W-1:0] = kp_pin;
            gpb_pkg::XP_DATA_OFF:
                rdata_d[PORT_W-1:0] = (xp_dir_q & xp_latch_q) | (~xp_dir_q & xp_pin); // RL3 RL4
            gpb_pkg::XP_DIR_OFF: rdata_d[PORT_W-1:0] = xp_dir_q;
            gpb_pkg::XP_PULL_OFF: rdata_d[PORT_W-1:0] = irq_port_pullup_ctrl_q;
            gpb_pkg::XP_PIN_OFF: rdata_d[PORT_W-1:0] = xp_pin;
            gpb_pkg::EDGE_OFF: rdata_d[gpb_pkg::EDGE_W-1:0] = irq_edge_select_q;
            gpb_pkg::IRQ_STAT_OFF: rdata_d[gpb_pkg::ST_W-1:0] = stat_q;
            gpb_pkg::IRQ_MASK_OFF: rdata_d[gpb_pkg::ST_W-1:0] = mask_q;
            default: rdata_d = gpb_pkg::RDATA_ZERO;
        endcase
    end

    // pready is low in reset and high from the first enabled edge on: every transfer completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else if (ce)
            pready <= 1'b1;
    end

    // error flag raised at the setup edge so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else if (ce)
            pslverr <= psel && !penable && !addr_ok;
    end

    // read data taken at the setup edge; it stands until the next read setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= gpb_pkg::RDATA_ZERO;
        else if (ce && psel && !penable && !pwrite)
            prdata <= rdata_d;
    end

    // keypad latch takes writes whatever the direction; the pin follows only as output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            kp_latch_q <= gpb_pkg::PORT_RST;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::KP_DATA_OFF)
            kp_latch_q <= pwdata[PORT_W-1:0]; // RL5
    end

    // irq port latch, same behaviour
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xp_latch_q <= gpb_pkg::PORT_RST;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::XP_DATA_OFF)
            xp_latch_q <= pwdata[PORT_W-1:0]; // RL5
    end

    // keypad direction, one bit per pin, cleared at reset so all pins float
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            kp_dir_q <= gpb_pkg::PORT_RST; // RL9
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::KP_DIR_OFF)
            kp_dir_q <= pwdata[PORT_W-1:0]; // RL1
    end

    // irq port direction, same scheme
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xp_dir_q <= gpb_pkg::PORT_RST; // RL9
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::XP_DIR_OFF)
            xp_dir_q <= pwdata[PORT_W-1:0]; // RL1
    end

    // keypad pull-up controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            keypad_pullup_ctrl_q <= gpb_pkg::PORT_RST;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::KP_PULL_OFF)
            keypad_pullup_ctrl_q <= pwdata[PORT_W-1:0]; // RL6
    end

    // irq port pull-up controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_port_pullup_ctrl_q <= gpb_pkg::PORT_RST;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::XP_PULL_OFF)
            irq_port_pullup_ctrl_q <= pwdata[PORT_W-1:0]; // RL7
    end

    // edge select per external line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_edge_select_q <= '0;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::EDGE_OFF)
            irq_edge_select_q <= pwdata[gpb_pkg::EDGE_W-1:0]; // RL7
    end

    // keypad drive: enable only where direction selects output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            keypad_port_out <= gpb_pkg::PORT_RST;
            keypad_port_oe <= gpb_pkg::PORT_RST;
        end
        else if (ce)
        begin
            keypad_port_out <= kp_latch_q & kp_dir_q; // RL2
            keypad_port_oe <= kp_dir_q; // RL2 RL4
        end
    end

    // irq port drive, same scheme
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_irq_port_out <= gpb_pkg::PORT_RST;
            ext_irq_port_oe <= gpb_pkg::PORT_RST;
        end
        else if (ce)
        begin
            ext_irq_port_out <= xp_latch_q & xp_dir_q; // RL2
            ext_irq_port_oe <= xp_dir_q; // RL2 RL4
        end
    end

    // pull-up enables; a pull-up on a driven pin would only waste current
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            keypad_pullup_en <= gpb_pkg::PORT_RST;
            irq_port_pullup_en <= gpb_pkg::PORT_RST;
        end
        else if (ce)
        begin
            keypad_pullup_en <= keypad_pullup_ctrl_q & ~kp_dir_q; // RL6
            irq_port_pullup_en <= irq_port_pullup_ctrl_q & ~xp_dir_q; // RL7
        end
    end

    // key wake-up: AND of input pins only; output pins count as 1.
    // with no input pins the AND stays 1, so no request can fire
    assign kp_and_d = &(kp_pin | kp_dir_q); // RL8
    assign ext_irq_line_a = xp_pin[gpb_pkg::IRQ_A_PIN] ^ !irq_edge_select_q[gpb_pkg::EDGE_A_BIT];
    assign ext_irq_line_b = xp_pin[gpb_pkg::IRQ_B_PIN] ^ !irq_edge_select_q[gpb_pkg::EDGE_B_BIT];

    // key AND history; resets to 0, the AND of the synchronised pins at reset,
    // so no false key press follows reset while the pins settle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            kp_and_q <= 1'b0;
        else if (ce)
            kp_and_q <= kp_and_d;
    end

    // line history; edge select 1 = rising, 0 = falling.
    // flipping the select can look like an edge: mask the line while changing it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_irq_line_a_q <= 1'b1;
            ext_irq_line_b_q <= 1'b1;
        end
        else if (ce)
        begin
            ext_irq_line_a_q <= ext_irq_line_a;
            ext_irq_line_b_q <= ext_irq_line_b;
        end
    end

    // events: key AND falling, and the selected edge of each irq line
    always_comb
    begin
        ev_set = '0;
        ev_set[gpb_pkg::ST_KEY_BIT] = kp_and_q && !kp_and_d; // RL8
        ev_set[gpb_pkg::ST_A_BIT] = !ext_irq_line_a_q && ext_irq_line_a; // RL7
        ev_set[gpb_pkg::ST_B_BIT] = !ext_irq_line_b_q && ext_irq_line_b; // RL7
    end

    // sticky status, write one to clear; a new event wins over its clear
    genvar k;
    generate
        for (k = 0; k < gpb_pkg::ST_W; k++)
        begin : g_stat
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    stat_q[k] <= 1'b0;
                else if (ce)
                begin
                    if (wr_en && paddr == gpb_pkg::IRQ_STAT_OFF && pwdata[k] && wmask[k])
                        stat_q[k] <= ev_set[k];
                    else
                        stat_q[k] <= stat_q[k] | ev_set[k];
                end
            end
        end
    endgenerate

    // interrupt mask, 1 lets the status bit through
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= '0;
        else if (wr_en && pstrb[0] && paddr == gpb_pkg::IRQ_MASK_OFF)
            mask_q <= pwdata[gpb_pkg::ST_W-1:0];
    end

    // level interrupt, registered so it leaves straight from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else if (ce)
            irq <= |(stat_q & mask_q);
    end
endmodule

// ### gpb_port_bank_sva.sv
// checker: port-level properties of the gpio port bank
`timescale 1ns/1ps
module gpb_port_bank_sva #(
    parameter int unsigned PORT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic [PORT_W-1:0] keypad_port_out,
    input wire logic [PORT_W-1:0] keypad_port_oe,
    input wire logic [PORT_W-1:0] keypad_pullup_en,
    input wire logic [PORT_W-1:0] ext_irq_port_out,
    input wire logic [PORT_W-1:0] ext_irq_port_oe,
    input wire logic [PORT_W-1:0] irq_port_pullup_en,
    input wire logic irq
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // a write lands only on the completing edge, and only lane 0 counts
    logic wr_ok;
    assign wr_ok = psel && penable && pwrite && ce && pstrb[0];
    kp_dir_a: assert property (wr_ok && paddr == gpb_pkg::KP_DIR_OFF
        |-> ##2 keypad_port_oe == $past(pwdata[PORT_W-1:0], 2)) else $error("kp oe wrong");
    xp_dir_a: assert property (wr_ok && paddr == gpb_pkg::XP_DIR_OFF
        |-> ##2 ext_irq_port_oe == $past(pwdata[PORT_W-1:0], 2)) else $error("xp oe wrong");
    kp_float_a: assert property ((keypad_port_out & ~keypad_port_oe) == '0)
        else $error("kp input driven");
    xp_float_a: assert property ((ext_irq_port_out & ~ext_irq_port_oe) == '0)
        else $error("xp input driven");
    kp_pull_a: assert property (wr_ok && paddr == gpb_pkg::KP_PULL_OFF |-> ##2
        keypad_pullup_en == ($past(pwdata[PORT_W-1:0], 2) & ~keypad_port_oe))
        else $error("kp pull wrong");
    xp_pull_a: assert property (wr_ok && paddr == gpb_pkg::XP_PULL_OFF |-> ##2
        irq_port_pullup_en == ($past(pwdata[PORT_W-1:0], 2) & ~ext_irq_port_oe))
        else $error("xp pull wrong");
    rd_latch_a: assert property (psel && penable && !pwrite && paddr == gpb_pkg::KP_DATA_OFF
        |-> ((prdata[PORT_W-1:0] ^ keypad_port_out) & keypad_port_oe) == '0)
        else $error("output read not latch");
    reset_dir_a: assert property ($rose(presetn)
        |-> ((keypad_port_oe | ext_irq_port_oe) == '0) [*2]) else $error("oe after reset");
    cover property (wr_ok && paddr == gpb_pkg::XP_DIR_OFF);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule

bind gpb_port_bank gpb_port_bank_sva #(.PORT_W(PORT_W)) u_sva (.*);

// ### gpb_pin_model.sv
// pin-side model: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module gpb_pin_model (
    input wire logic pclk,
    input wire logic [7:0] drv_out,
    input wire logic [7:0] drv_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin
);
    logic [7:0] wander_q = 8'h5a;
    // undriven lines without pull-up wander, so no level is taken for granted
    always_ff @(posedge pclk)
    begin
        wander_q <= ~wander_q;
    end
    // device drive wins, then the outside driver, then the pull-up
    assign pin = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
        | (~drv_oe & ~ext_en & (pull_en | wander_q));
endmodule

// ### gpb_port_bank_bench.sv
// self-checking bench for the gpio port bank
`timescale 1ns/1ps
module gpb_port_bank_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, se;
    logic [7:0] kp_in, kp_out, kp_oe, kp_pu, xp_in, xp_out, xp_oe, xp_pu;
    logic [7:0] ev [2];
    logic [7:0] ee [2];
    int errors = 0;
    int check_count = 0;
    // clock of 4 ns
    always #2 pclk = ~pclk;
    gpb_port_bank DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .keypad_port_in(kp_in), .keypad_port_out(kp_out), .keypad_port_oe(kp_oe),
        .keypad_pullup_en(kp_pu), .ext_irq_port_in(xp_in), .ext_irq_port_out(xp_out),
        .ext_irq_port_oe(xp_oe), .irq_port_pullup_en(xp_pu), .irq(irq));
    gpb_pin_model kp_pins (.pclk(pclk), .drv_out(kp_out), .drv_oe(kp_oe),
        .pull_en(kp_pu), .ext_val(ev[0]), .ext_en(ee[0]), .pin(kp_in));
    gpb_pin_model xp_pins (.pclk(pclk), .drv_out(xp_out), .drv_oe(xp_oe),
        .pull_en(xp_pu), .ext_val(ev[1]), .ext_en(ee[1]), .pin(xp_in));
    task results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            results();
        end
        @(posedge pclk);
    endtask
    task wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, irq}, {31'h0, v});
        if (irq !== v)
            results();
    endtask
    // pin level: own drive, else outside driver, else pull-up
    function automatic logic [7:0] exp_pin(input logic [7:0] d, l, v, e, u);
        return (d & l) | (~d & e & v) | (~d & ~e & u);
    endfunction
    initial
    begin
        logic [7:0] d, l, u, m;
        logic [11:0] b;
        int p;
        ev[0] = 8'hff;
        ev[1] = 8'h01;
        ee[0] = 8'hff;
        ee[1] = 8'hff;
        void'($urandom(32'h27fe6543));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, gpb_pkg::KP_DIR_OFF, 32'h0);
        chk(rd, 32'h0);
        repeat (12)
        begin
            p = $urandom_range(1, 0);
            b = 12'(p * 16);
            d = 8'($urandom);
            l = 8'($urandom);
            u = 8'($urandom);
            ev[p] <= 8'($urandom);
            ee[p] <= 8'($urandom);
            apb(1'b1, gpb_pkg::KP_DATA_OFF + b, {24'h0, l});
            apb(1'b1, gpb_pkg::KP_PULL_OFF + b, {24'h0, u});
            apb(1'b1, gpb_pkg::KP_DIR_OFF + b, {24'h0, d});
            repeat (8) @(posedge pclk);
            m = d | ee[p] | u;
            apb(1'b0, gpb_pkg::KP_PIN_OFF + b, 32'h0);
            chk(rd & {24'h0, m}, {24'h0, exp_pin(d, l, ev[p], ee[p], u) & m});
            apb(1'b0, gpb_pkg::KP_DATA_OFF + b, 32'h0);
            chk(rd & {24'h0, m}, {24'h0, exp_pin(d, l, ev[p], ee[p], u) & m});
        end
        ev[0] <= 8'hff;
        ev[1] <= 8'h01;
        ee[0] <= 8'hff;
        ee[1] <= 8'hff;
        apb(1'b1, gpb_pkg::KP_DIR_OFF, 32'h0);
        apb(1'b1, gpb_pkg::XP_DIR_OFF, 32'h0);
        apb(1'b1, gpb_pkg::EDGE_OFF, 32'h2);
        apb(1'b1, gpb_pkg::IRQ_MASK_OFF, 32'h7);
        repeat (8) @(posedge pclk);
        apb(1'b1, gpb_pkg::IRQ_STAT_OFF, 32'h7);
        wait_irq(1'b0);
        ev[0] <= 8'hf7;
        wait_irq(1'b1);
        apb(1'b0, gpb_pkg::IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, gpb_pkg::IRQ_STAT_OFF, 32'h1);
        wait_irq(1'b0);
        ev[1] <= 8'h04;
        wait_irq(1'b1);
        repeat (4) @(posedge pclk);
        apb(1'b0, gpb_pkg::IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h6);
        ev[0] <= 8'hff;
        apb(1'b1, gpb_pkg::IRQ_MASK_OFF, 32'h0);
        apb(1'b1, gpb_pkg::IRQ_STAT_OFF, 32'h7);
        ev[0] <= 8'hfe;
        repeat (12) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, gpb_pkg::IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h02c, 32'h0);
        chk({se, rd[30:0]}, 32'h80000000);
        ce <= 1'b0;
        apb(1'b1, gpb_pkg::KP_DIR_OFF, 32'hff);
        ce <= 1'b1;
        apb(1'b0, gpb_pkg::KP_DIR_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, gpb_pkg::XP_DIR_OFF, 32'hff);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, gpb_pkg::XP_DIR_OFF, 32'h0);
        chk(rd, 32'h0);
        results();
    end
endmodule
